/* design/hpp_regs.svh */
// Register offsets, field positions and reset values of the host parallel port.
`ifndef HPP_REGS_SVH
`define HPP_REGS_SVH
`define HPP_OFF_CONTROL      4'h0
`define HPP_OFF_DATA         4'h1
`define HPP_OFF_OUT_LATCH    4'h2
`define HPP_OFF_DIRECTION    4'h3
`define HPP_OFF_STROBE_VAL   4'h4
`define HPP_OFF_STROBE_LAT   4'h5
`define HPP_OFF_STROBE_DIR   4'h6
`define HPP_OFF_IRQ_FLAGS    4'h7
`define HPP_OFF_IRQ_EN       4'h8
`define HPP_OFF_IRQ_PRIO     4'h9
`define HPP_OFF_ANALOG_CFG   4'ha
`define HPP_OFF_MEM_MODE     4'hb
`define HPP_BIT_IN_FULL      7
`define HPP_BIT_OUT_FULL     6
`define HPP_BIT_OVERFLOW     5
`define HPP_BIT_MODE         4
`define HPP_BIT_IRQ          7
`define HPP_RST_CONTROL      8'h00
`define HPP_RST_DIRECTION    8'hff
`define HPP_RST_STROBE_DIR   8'hff
`define HPP_RST_IRQ_FLAGS    8'h00
`define HPP_RST_IRQ_EN       8'h00
`define HPP_RST_IRQ_PRIO     8'hff
`define HPP_RST_ANALOG_CFG   8'h00
`define HPP_RST_STROBE_LAT   8'h00
`define HPP_RST_LATCH        8'h00
`endif

/* design/hpp_pkg.sv */
// Types shared by the host parallel port design.
package hpp_pkg;
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic cs_n;
   } hpp_strobe_t;
   typedef struct packed {
      logic [7:0] in;
      logic [7:0] out;
      logic [7:0] oe;
   } hpp_pins_t;
endpackage

/* design/hpp_top.sv */
// Host parallel port: byte-wide slave port for an external processor.
// Functional notes
// - Mode bit selects slave port or GPIO.
// - Three strobe pins become read, write, select.
// - External processor accesses one byte-wide latch.
// - Strobe direction bits must be inputs.
// - Analog config bits must make pins digital.
// - Write taken when select and write low.
// - Read begins when select and read low.
// - Strobe pins are control inputs in mode.
// - Input-full bit 7 shows unread byte.
// - Output-full bit 6 shows unread output byte.
// - Overflow bit 5 sticky until software clears.
// - Low control bits read zero, reset zero.
// - Port usable only in microcontroller mode.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`include "hpp_regs.svh"
module hpp_top (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [3:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic [7:0]        pd_in,
   output logic      [7:0]        pd_out,
   output logic      [7:0]        pd_oe,
   input  wire logic [7:0]        pe_in,
   output logic      [7:0]        pe_out,
   output logic      [7:0]        pe_oe,
   output logic                   irq
);
   // Control and data registers.
   logic [7:0] ctrl_ff;
   logic [7:0] latch_ff;
   logic [7:0] dir_ff;
   logic [7:0] elat_ff;
   logic [7:0] edir_ff;
   logic [7:0] flags_ff;
   logic [7:0] en_ff;
   logic [7:0] prio_ff;
   logic [7:0] acfg_ff;
   logic       ext_mem_ff;
   logic       wr_seen_ff;
   logic       rd_seen_ff;
   logic       ack_ff;
   logic [31:0] rdata_ff;
   logic [7:0] pd_out_ff;
   logic [7:0] pd_oe_ff;
   logic [7:0] pe_out_ff;
   logic [7:0] pe_oe_ff;
   logic       irq_ff;

   hpp_pkg::hpp_strobe_t strb;

   // Decode of strobes and bus access.
   wire req = (avs_read | avs_write) & ~ack_ff;
   wire wr_req = avs_write & ~ack_ff;
   wire rd_req = avs_read & ~ack_ff;
   wire digital_ok = &acfg_ff[2:0];
   wire inputs_ok = &edir_ff[2:0];
   wire mode_on = ctrl_ff[`HPP_BIT_MODE] & ~ext_mem_ff;
   assign strb.rd_n = pe_in[0];
   assign strb.wr_n = pe_in[1];
   assign strb.cs_n = pe_in[2];
   wire port_live = mode_on & digital_ok & inputs_ok;
   wire ext_wr_lvl = port_live & ~strb.cs_n & ~strb.wr_n;
   wire ext_rd_lvl = port_live & ~strb.cs_n & ~strb.rd_n;
   wire ext_wr_end = wr_seen_ff & ~ext_wr_lvl;
   wire ext_rd_end = rd_seen_ff & ~ext_rd_lvl;
   wire sel_ctrl = (avs_address == `HPP_OFF_CONTROL);
   wire sel_data = (avs_address == `HPP_OFF_DATA);
   wire sel_lat = (avs_address == `HPP_OFF_OUT_LATCH);
   wire cpu_data_wr = wr_req & (sel_data | sel_lat);
   wire cpu_data_rd = rd_req & sel_data;
   wire [7:0] wbyte = avs_writedata[7:0];

   // Input-full, output-full and overflow next values.
   wire in_full = ctrl_ff[`HPP_BIT_IN_FULL];
   wire nxt_in_full = ext_wr_end | (in_full & ~cpu_data_rd);
   wire nxt_out_full = (cpu_data_wr & mode_on)
                     | (ctrl_ff[`HPP_BIT_OUT_FULL] & ~ext_rd_end);
   wire ovf_clr = wr_req & sel_ctrl & ~avs_writedata[`HPP_BIT_OVERFLOW];
   wire nxt_ovf = (ext_wr_end & in_full)
                | (ctrl_ff[`HPP_BIT_OVERFLOW] & ~ovf_clr);
   wire nxt_mode = (wr_req & sel_ctrl) ? avs_writedata[`HPP_BIT_MODE]
                                       : ctrl_ff[`HPP_BIT_MODE];
   wire [7:0] nxt_ctrl = {nxt_in_full, nxt_out_full, nxt_ovf, nxt_mode, 4'h0};

   // Interrupt flag: set by either transfer end; set wins over clear.
   wire evt = ext_wr_end | ext_rd_end;
   // Flags are write-one-to-clear, so an event landing with the clear is kept.
   wire [7:0] flag_w = (wr_req && avs_address == `HPP_OFF_IRQ_FLAGS) ? (flags_ff & ~wbyte)
                                                                     : flags_ff;
   wire [7:0] nxt_flags = {flag_w[7] | evt, flag_w[6:0]};

   // Pin data: the external byte lands in the latch, CPU writes load it too.
   wire [7:0] nxt_latch = ext_wr_end ? pd_in :
                          cpu_data_wr ? wbyte : latch_ff;
   wire [7:0] nxt_pd_oe = ext_rd_lvl ? 8'hff :
                          mode_on ? 8'h00 : ~dir_ff;

   // Read data mux.
   logic [7:0] rsel;
   always_comb begin
      if (sel_ctrl) begin
         rsel = ctrl_ff;
      end else if (sel_data) begin
         rsel = mode_on ? latch_ff : pd_in;
      end else if (sel_lat) begin
         rsel = latch_ff;
      end else if (avs_address == `HPP_OFF_DIRECTION) begin
         rsel = dir_ff;
      end else if (avs_address == `HPP_OFF_STROBE_VAL) begin
         rsel = pe_in;
      end else if (avs_address == `HPP_OFF_STROBE_LAT) begin
         rsel = elat_ff;
      end else if (avs_address == `HPP_OFF_STROBE_DIR) begin
         rsel = edir_ff;
      end else if (avs_address == `HPP_OFF_IRQ_FLAGS) begin
         rsel = flags_ff;
      end else if (avs_address == `HPP_OFF_IRQ_EN) begin
         rsel = en_ff;
      end else if (avs_address == `HPP_OFF_IRQ_PRIO) begin
         rsel = prio_ff;
      end else if (avs_address == `HPP_OFF_ANALOG_CFG) begin
         rsel = acfg_ff;
      end else if (avs_address == `HPP_OFF_MEM_MODE) begin
         rsel = {7'h00, ext_mem_ff};
      end else begin
         rsel = 8'h00;
      end
   end

   // Transfer detection: the strobe level is seen first, the end follows.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_seen_ff <= 1'b0;
         rd_seen_ff <= 1'b0;
      end else begin
         wr_seen_ff <= ext_wr_lvl;
         rd_seen_ff <= ext_rd_lvl;
      end
   end

   // Status, latch and interrupt registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff  <= `HPP_RST_CONTROL;
         latch_ff <= `HPP_RST_LATCH;
         flags_ff <= `HPP_RST_IRQ_FLAGS;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         latch_ff <= nxt_latch;
         flags_ff <= nxt_flags;
      end
   end

   // Plain software registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_ff     <= `HPP_RST_DIRECTION;
         elat_ff    <= `HPP_RST_STROBE_LAT;
         edir_ff    <= `HPP_RST_STROBE_DIR;
         en_ff      <= `HPP_RST_IRQ_EN;
         prio_ff    <= `HPP_RST_IRQ_PRIO;
         acfg_ff    <= `HPP_RST_ANALOG_CFG;
         ext_mem_ff <= 1'b0;
      end else if (wr_req) begin
         if (avs_address == `HPP_OFF_DIRECTION) begin
            dir_ff <= wbyte;
         end else if (avs_address == `HPP_OFF_STROBE_LAT) begin
            elat_ff <= wbyte;
         end else if (avs_address == `HPP_OFF_STROBE_DIR) begin
            edir_ff <= wbyte;
         end else if (avs_address == `HPP_OFF_IRQ_EN) begin
            en_ff <= wbyte;
         end else if (avs_address == `HPP_OFF_IRQ_PRIO) begin
            prio_ff <= wbyte;
         end else if (avs_address == `HPP_OFF_ANALOG_CFG) begin
            acfg_ff <= wbyte;
         end else if (avs_address == `HPP_OFF_MEM_MODE) begin
            ext_mem_ff <= wbyte[0];
         end
      end
   end

   // Bus answer: one wait cycle, then the acknowledge cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff   <= req;
         rdata_ff <= {24'h00_0000, rsel};
      end
   end

   // Pin drivers and interrupt output, all registered.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pd_out_ff <= 8'h00;
         pd_oe_ff  <= 8'h00;
         pe_out_ff <= 8'h00;
         pe_oe_ff  <= 8'h00;
         irq_ff    <= 1'b0;
      end else begin
         pd_out_ff <= latch_ff;
         pd_oe_ff  <= nxt_pd_oe;
         pe_out_ff <= elat_ff;
         pe_oe_ff  <= mode_on ? {~edir_ff[7:3], 3'h0} : ~edir_ff;
         irq_ff    <= |(nxt_flags & en_ff);
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = ~ack_ff;
   assign pd_out = pd_out_ff;
   assign pd_oe  = pd_oe_ff;
   assign pe_out = pe_out_ff;
   assign pe_oe  = pe_oe_ff;
   assign irq    = irq_ff;
endmodule

/* tb/hpp_ext_cpu.sv */
// External processor model that drives the port's strobe and data pins.
`timescale 1ns/10ps
module hpp_ext_cpu (
   input  wire logic       clk,
   output logic      [7:0] pe_in,
   output logic      [7:0] pd_in,
   input  wire logic [7:0] pd_out,
   input  wire logic [7:0] pd_oe
);
   logic [7:0] drv_ff;
   logic       own_ff;
   // Strobes idle high; a released data bus shows the inverse of the last byte.
   initial begin
      pe_in = 8'h07;
      drv_ff = 8'h00;
      own_ff = 1'b0;
   end
   // The wire carries the port's byte while it drives, else the model's own byte, inverted once the model releases it.
   assign pd_in = (pd_oe == 8'hff) ? pd_out : (own_ff ? drv_ff : ~drv_ff);
   // Write cycle: select and write low with data, data held past the rising strobes.
   task automatic wr(input logic [7:0] d);
      @(posedge clk);
      drv_ff <= d;
      own_ff <= 1'b1;
      pe_in <= 8'h01;
      repeat (3) @(posedge clk);
      pe_in <= 8'h07;
      repeat (2) @(posedge clk);
      own_ff <= 1'b0;
      @(posedge clk);
   endtask
   // Read cycle: select and read low, byte taken before the strobes rise.
   task automatic rd(output logic [7:0] d);
      @(posedge clk);
      pe_in <= 8'h02;
      repeat (3) @(posedge clk);
      d = pd_in;
      pe_in <= 8'h07;
      repeat (2) @(posedge clk);
   endtask
endmodule

/* tb/hpp_top_asserts.sv */
// Concurrent checks on the host port's bus, data pin and interrupt outputs.
`timescale 1ns/10ps
module hpp_top_asserts (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [7:0]  pd_oe,
   input wire logic [7:0]  pe_in,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge held longer than one cycle");
   a_ack_timely: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not acknowledged on the next cycle");
   a_ack_caused: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
      else $error("acknowledge without a request");
   a_upper_zero: assert property (!avs_waitrequest && $past(avs_read) |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   a_drive_cause: assert property (pd_oe != 8'h00 |-> $past(!pe_in[0] && !pe_in[2]))
      else $error("data pins driven without select and read low");
   a_drive_stop: assert property (pe_in[2] |=> pd_oe == 8'h00)
      else $error("data pins still driven after select released");
   a_idle_quiet: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge while the bus is idle");
   a_irq_reset: assert property ($fell(rst) |-> !irq)
      else $error("interrupt high right after reset");
endmodule

/* tb/hpp_top_bench.sv */
// Self-checking bench for the host parallel port.
`timescale 1ns/10ps
`include "hpp_regs.svh"
module hpp_top_bench;
   logic        clk, rst, avs_read, avs_write, avs_waitrequest, irq;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0]  pd_in, pd_out, pd_oe, pe_in, pe_out, pe_oe, got;
   int          bad_count, checks;
   hpp_top DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
      .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe), .irq(irq));
   hpp_ext_cpu ext (.clk(clk), .pe_in(pe_in), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe));
   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Compares one byte and reports a difference at once.
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask
   // One bus transfer, held until waitrequest is sampled low.
   // The watchdog alone ends a wait that never sees waitrequest low.
   task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_write <= we;
      avs_read <= !we;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      got = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(got, e, "register read");
   endtask
   task automatic ck_irq(input logic e);
      repeat (2) @(posedge clk);
      chk({7'h0, irq}, {7'h0, e}, "interrupt level");
   endtask
   task automatic t_reset;
      rc(`HPP_OFF_CONTROL, 8'h00);
      rc(`HPP_OFF_DIRECTION, 8'hff);
      rc(`HPP_OFF_STROBE_DIR, 8'hff);
      rc(`HPP_OFF_IRQ_PRIO, 8'hff);
      rc(`HPP_OFF_IRQ_FLAGS, 8'h00);
      rc(4'hc, 8'h00);
      $display("test reset values done");
   endtask
   task automatic t_ext_write;
      bus(1'b1, `HPP_OFF_ANALOG_CFG, 8'h07);
      bus(1'b1, `HPP_OFF_CONTROL, 8'hdf);
      rc(`HPP_OFF_CONTROL, 8'h10);
      bus(1'b1, `HPP_OFF_IRQ_EN, 8'h80);
      bus(1'b1, `HPP_OFF_STROBE_DIR, 8'h07);
      repeat (2) @(posedge clk);
      chk(pe_oe, 8'hf8, "strobe pins not inputs in port mode");
      ext.wr(8'ha5);
      rc(`HPP_OFF_CONTROL, 8'h90);
      ck_irq(1'b1);
      ext.wr(8'h3c);
      rc(`HPP_OFF_CONTROL, 8'hb0);
      rc(`HPP_OFF_DATA, 8'h3c);
      rc(`HPP_OFF_CONTROL, 8'h30);
      bus(1'b1, `HPP_OFF_CONTROL, 8'h10);
      rc(`HPP_OFF_CONTROL, 8'h10);
      $display("test external write done");
   endtask
   task automatic t_irq;
      bus(1'b1, `HPP_OFF_IRQ_EN, 8'h00);
      ck_irq(1'b0);
      bus(1'b1, `HPP_OFF_IRQ_EN, 8'h80);
      ck_irq(1'b1);
      bus(1'b1, `HPP_OFF_IRQ_FLAGS, 8'h80);
      ck_irq(1'b0);
      $display("test interrupt mask done");
   endtask
   task automatic t_ext_read;
      logic [7:0] b;
      bus(1'b1, `HPP_OFF_DATA, 8'h5a);
      rc(`HPP_OFF_CONTROL, 8'h50);
      chk(pd_out, 8'h5a, "data pin output byte");
      ext.rd(b);
      chk(b, 8'h5a, "external read byte");
      rc(`HPP_OFF_CONTROL, 8'h10);
      ck_irq(1'b1);
      bus(1'b1, `HPP_OFF_IRQ_FLAGS, 8'h80);
      $display("test external read done");
   endtask
   task automatic t_gpio;
      bus(1'b1, `HPP_OFF_CONTROL, 8'h00);
      ext.wr(8'h77);
      rc(`HPP_OFF_CONTROL, 8'h00);
      ck_irq(1'b0);
      $display("test general purpose mode done");
   endtask
   // Reset, then the scenarios in turn.
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_ext_write();
      t_irq();
      t_ext_read();
      t_gpio();
      stop_test();
   end
   // Cuts a hang short.
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule
bind hpp_top hpp_top_asserts u_chk (.clk(clk), .rst(rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .pd_oe(pd_oe), .pe_in(pe_in), .irq(irq));
